// *** pkg/mcp_pkg.sv ***
// Shared constants, types and helpers for the calibration and password bank.
package mcp_pkg;

  // Byte offsets of the bank.
  localparam logic [7:0] SHIFT_ADDR = 8'h8f;
  localparam logic [7:0] RSVD_A_ADDR = 8'h90;
  localparam logic [7:0] SUPPLY_GAIN_ADDR = 8'h92;
  localparam logic [7:0] EXTERNAL_MONITOR_ONE_GAIN_ADDR = 8'h94;
  localparam logic [7:0] EXTERNAL_MONITOR_TWO_GAIN_ADDR = 8'h96;
  localparam logic [7:0] EXTERNAL_MONITOR_THREE_GAIN_ADDR = 8'h98;
  localparam logic [7:0] RSVD_B_ADDR = 8'h9a;
  localparam logic [7:0] SUPPLY_OFFSET_ADDR = 8'ha2;
  localparam logic [7:0] MONITOR_ONE_OFFSET_ADDR = 8'ha4;
  localparam logic [7:0] MONITOR_TWO_OFFSET_ADDR = 8'ha6;
  localparam logic [7:0] MONITOR_THREE_OFFSET_ADDR = 8'ha8;
  localparam logic [7:0] RSVD_C_ADDR = 8'haa;
  localparam logic [7:0] TEMP_OFFSET_ADDR = 8'hae;
  localparam logic [7:0] PW1_ADDR = 8'hb0;
  localparam logic [7:0] PW2_ADDR = 8'hb4;
  localparam logic [7:0] CAL_FIRST = 8'h8f;
  localparam logic [7:0] CAL_LAST = 8'haf;
  localparam logic [7:0] PW_LAST = 8'hb7;

  // Calibration store geometry.
  localparam int MEM_DEPTH = 33;
  localparam logic [5:0] MEM_LAST_IDX = 6'h20;

  // Third-monitor shift field within the shift byte.
  localparam int SHIFT_LSB = 4;
  localparam int SHIFT_MSB = 6;

  // Key that the host folds into the temperature offset word.
  localparam logic [15:0] TEMP_OFFSET_KEY = 16'hbb40;

  // Values after reset.
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [7:0] RSVD_RESET = 8'h00;
  localparam logic [15:0] SUPPLY_GAIN_RESET = 16'h8000;
  localparam logic [15:0] MON_GAIN_RESET = 16'h8000;
  localparam logic [15:0] TEMP_OFFSET_RESET = 16'hbb40;
  localparam logic [31:0] PASSWORD_RESET = 32'hffffffff;
  localparam logic [31:0] PWE_RESET = 32'hffffffff;
  localparam logic [7:0] READ_HIDDEN = 8'h00;

  // Measurement channels.
  typedef logic [2:0] chan_t;
  localparam chan_t CH_SUPPLY = 3'h0;
  localparam chan_t CH_EXTERNAL_MONITOR_ONE = 3'h1;
  localparam chan_t CH_EXTERNAL_MONITOR_TWO = 3'h2;
  localparam chan_t CH_EXTERNAL_MONITOR_THREE = 3'h3;
  localparam chan_t CH_TEMP = 3'h4;

  function automatic logic [5:0] cal_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - CAL_FIRST;
    return diff[5:0];
  endfunction : cal_index

  function automatic logic [7:0] factory_byte(input logic [5:0] idx);
    logic [7:0] addr;
    addr = CAL_FIRST + {2'h0, idx};
    unique case (addr)
      SHIFT_ADDR: return SHIFT_RESET;
      SUPPLY_GAIN_ADDR: return SUPPLY_GAIN_RESET[15:8];
      SUPPLY_GAIN_ADDR + 8'h01: return SUPPLY_GAIN_RESET[7:0];
      EXTERNAL_MONITOR_ONE_GAIN_ADDR, EXTERNAL_MONITOR_TWO_GAIN_ADDR, EXTERNAL_MONITOR_THREE_GAIN_ADDR:
        return MON_GAIN_RESET[15:8];
      EXTERNAL_MONITOR_ONE_GAIN_ADDR + 8'h01, EXTERNAL_MONITOR_TWO_GAIN_ADDR + 8'h01,
      EXTERNAL_MONITOR_THREE_GAIN_ADDR + 8'h01: return MON_GAIN_RESET[7:0];
      SUPPLY_OFFSET_ADDR, MONITOR_ONE_OFFSET_ADDR, MONITOR_TWO_OFFSET_ADDR,
      MONITOR_THREE_OFFSET_ADDR: return OFFSET_RESET[15:8];
      TEMP_OFFSET_ADDR: return TEMP_OFFSET_RESET[15:8];
      TEMP_OFFSET_ADDR + 8'h01: return TEMP_OFFSET_RESET[7:0];
      default: return RSVD_RESET;
    endcase
  endfunction : factory_byte

  // Replaces one byte of a word; byte 0 is the most significant.
  function automatic logic [31:0] put_byte(input logic [31:0] word,
                                           input logic [1:0] lane,
                                           input logic [7:0] data);
    logic [31:0] res;
    res = word;
    unique case (lane)
      2'h0: res[31:24] = data;
      2'h1: res[23:16] = data;
      2'h2: res[15:8] = data;
      2'h3: res[7:0] = data;
    endcase
    return res;
  endfunction : put_byte

endpackage : mcp_pkg

// *** pkg/mcp_nvm_if.sv ***
// Connection between the bank controller and its calibration store.
`timescale 1ns/1ps
interface mcp_nvm_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic [5:0] cal_idx;
  logic [15:0] cal_word;
  modport store (
    input wr_en, wr_idx, wr_data, rd_idx, cal_idx,
    output rd_data, cal_word
  );
  modport user (
    output wr_en, wr_idx, wr_data, rd_idx, cal_idx,
    input rd_data, cal_word
  );
endinterface : mcp_nvm_if

// *** hdl/mcp_nvm.sv ***
// Calibration byte store with a byte read port and a word read port.
`timescale 1ns/1ps
module mcp_nvm (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Controller side
  mcp_nvm_if.store port
);
  import mcp_pkg::*;

  logic [7:0] mem_r [MEM_DEPTH];

  // Reset stands in for the factory content being reloaded at power-on.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= factory_byte(6'(i));
      end
    end else if (port.wr_en && port.wr_idx <= MEM_LAST_IDX) begin
      mem_r[port.wr_idx] <= port.wr_data;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      port.rd_data <= 8'h00;
    end else if (port.rd_idx <= MEM_LAST_IDX) begin
      port.rd_data <= mem_r[port.rd_idx];
    end else begin
      port.rd_data <= 8'h00;
    end
  end

  // Word reads are high byte first; the last byte has no partner.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      port.cal_word <= 16'h0000;
    end else if (port.cal_idx < MEM_LAST_IDX) begin
      port.cal_word <= {mem_r[port.cal_idx], mem_r[port.cal_idx + 6'h01]};
    end else begin
      port.cal_word <= 16'h0000;
    end
  end

endmodule : mcp_nvm

// *** hdl/mcp_bank.sv ***
// Monitor calibration and two-level password bank with measurement path.
`timescale 1ns/1ps
// What this block does
// - Third-monitor result is right-shifted by bits 6:4 of the shift byte.
// - Bytes 90h-91h, 9Ah-A1h, AAh-ADh are plain storage, reset zero.
// - Supply gain word at 92h, high byte first, scales supply readings.
// - Monitor gain words at 94h, 96h, 98h scale the three monitors.
// - Signed supply offset at A2h, weights 2^15..2^2, default zero.
// - Signed monitor offsets at A4h, A6h, A8h, same format, zero.
// - Signed temperature offset at AEh, weights 2^8..2^-6, added.
// - First-level access while entry value equals password at B0h.
// - Second-level access while entry value equals password at B4h.
// - Entry value resets to all ones.
// - All-ones second password grants access from reset without entry.
// - Password bytes always read as 00h.
// - Passwords reset to all ones, writable only with second-level access.
// - Calibration bytes readable and writable only with second-level access.
module mcp_bank (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Byte register port from the serial engine
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_denied_o,
  // Password entry and access levels
  input wire logic pwe_wr_i,
  input wire logic [31:0] password_entry_value_i,
  output logic first_level_access_o,
  output logic second_level_access_o,
  // Measurement path
  input wire logic meas_start_i,
  input wire mcp_pkg::chan_t meas_chan_i,
  input wire logic [15:0] meas_raw_i,
  output logic meas_busy_o,
  output logic meas_done_o,
  output logic [15:0] meas_result_o
);
  import mcp_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE,
    M_GAIN,
    M_OFFSET,
    M_SHIFT,
    M_DONE
  } mcp_meas_e;

  mcp_nvm_if nvm ();

  mcp_nvm u_nvm (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .port (nvm.store)
  );

  // Password state.
  logic [31:0] pwe_r;
  logic [31:0] pw1_r;
  logic [31:0] pw2_r;
  logic first_ok;
  logic second_ok;

  // Register port decode.
  logic cal_hit;
  logic pw_hit;
  logic req;
  logic granted;
  logic wr_ok;

  // Read pipeline.
  logic req_pend_r;
  logic rd_pend_r;
  logic rd_mem_r;
  logic denied_pend_r;

  // Measurement state.
  mcp_meas_e state_r;
  chan_t chan_r;
  logic [15:0] raw_r;
  logic [15:0] gain_r;
  logic [15:0] offset_r;
  logic [15:0] volt_res;
  logic [15:0] temp_res;
  logic [15:0] result_nxt;

  // Volatile entry value; it powers up as all ones. A host loads it to
  // unlock a level, and it is never kept across a reset.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pwe_r <= PWE_RESET;
    end else if (pwe_wr_i) begin
      pwe_r <= password_entry_value_i;
    end
  end

  // Levels follow the stored words at once, so a freshly written second
  // password can lock out the very host that wrote it.
  always_comb begin
    first_ok = (pwe_r == pw1_r);
    second_ok = (pwe_r == pw2_r);
  end

  assign first_level_access_o = first_ok;
  assign second_level_access_o = second_ok;

  // Address decode for the byte port; both password words sit just above
  // the calibration bytes, so the two ranges meet without a gap.
  always_comb begin
    cal_hit = (reg_addr_i >= CAL_FIRST) && (reg_addr_i <= CAL_LAST);
    pw_hit = (reg_addr_i >= PW1_ADDR) && (reg_addr_i <= PW_LAST);
    req = reg_wr_i || reg_rd_i;
    granted = second_ok && (cal_hit || pw_hit);
    wr_ok = reg_wr_i && granted;
  end

  // Reserved bytes are stored like any other calibration byte. Each byte
  // lands on its own, so a measurement started between the two halves of
  // a word uses the half-updated word; hosts should not rely on it.
  assign nvm.wr_en = wr_ok && cal_hit;
  assign nvm.wr_idx = cal_index(reg_addr_i);
  assign nvm.wr_data = reg_wdata_i;
  assign nvm.rd_idx = cal_index(reg_addr_i);

  // Stored passwords; bit 2 of the address picks the word, the low two
  // bits the byte, most significant byte at the lowest address. Like the
  // store, they take their factory value at every reset, so this model
  // does not carry host writes across a power cycle.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pw1_r <= PASSWORD_RESET;
      pw2_r <= PASSWORD_RESET;
    end else if (wr_ok && pw_hit) begin
      if (reg_addr_i[2]) begin
        pw2_r <= put_byte(pw2_r, reg_addr_i[1:0], reg_wdata_i);
      end else begin
        pw1_r <= put_byte(pw1_r, reg_addr_i[1:0], reg_wdata_i);
      end
    end
  end

  // First stage: remember what kind of answer is owed. Every strobe gets
  // an answer, even outside the bank, so a host never waits on a dead
  // address; the access check uses the level of the strobe's own cycle.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      req_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_mem_r <= 1'b0;
      denied_pend_r <= 1'b0;
    end else begin
      req_pend_r <= req;
      rd_pend_r <= reg_rd_i;
      rd_mem_r <= reg_rd_i && second_ok && cal_hit;
      denied_pend_r <= req && !granted;
    end
  end

  // Second stage: the store's registered data is ready, so present it.
  // Password bytes never reach this mux, they always read as zero.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_ack_o <= 1'b0;
      reg_denied_o <= 1'b0;
    end else begin
      reg_ack_o <= req_pend_r;
      reg_denied_o <= denied_pend_r;
      if (rd_pend_r) begin
        reg_rdata_o <= rd_mem_r ? nvm.rd_data : READ_HIDDEN;
      end
    end
  end

  // Calibration word addressed in each measurement step; its data arrives
  // one cycle later, in the following state.
  always_comb begin
    unique case (state_r)
      M_GAIN: begin
        unique case (chan_r)
          CH_EXTERNAL_MONITOR_ONE: nvm.cal_idx = cal_index(EXTERNAL_MONITOR_ONE_GAIN_ADDR);
          CH_EXTERNAL_MONITOR_TWO: nvm.cal_idx = cal_index(EXTERNAL_MONITOR_TWO_GAIN_ADDR);
          CH_EXTERNAL_MONITOR_THREE: nvm.cal_idx = cal_index(EXTERNAL_MONITOR_THREE_GAIN_ADDR);
          default: nvm.cal_idx = cal_index(SUPPLY_GAIN_ADDR);
        endcase
      end
      M_OFFSET: begin
        unique case (chan_r)
          CH_EXTERNAL_MONITOR_ONE: nvm.cal_idx = cal_index(MONITOR_ONE_OFFSET_ADDR);
          CH_EXTERNAL_MONITOR_TWO: nvm.cal_idx = cal_index(MONITOR_TWO_OFFSET_ADDR);
          CH_EXTERNAL_MONITOR_THREE: nvm.cal_idx = cal_index(MONITOR_THREE_OFFSET_ADDR);
          CH_TEMP: nvm.cal_idx = cal_index(TEMP_OFFSET_ADDR);
          default: nvm.cal_idx = cal_index(SUPPLY_OFFSET_ADDR);
        endcase
      end
      default: nvm.cal_idx = cal_index(SHIFT_ADDR);
    endcase
  end

  // Voltage channels: gain, then offset, clamped to the unsigned range.
  // The shift byte is on the word port by the final step, so the third
  // monitor's shift amount is taken from there.
  always_comb begin
    logic [31:0] prod;
    logic [18:0] sum;
    logic [15:0] clamped;
    logic [7:0] shift_byte;
    logic [2:0] shift_amt;
    prod = raw_r * gain_r;
    // Offset bits 13:0 carry weights 2^15..2^2, so the word times four
    // lines it up with the gained reading; only the offset's sign bit extends, the reading is zero-extended.
    sum = {3'h0, prod[31:16]} + {offset_r[15], offset_r, 2'h0};
    clamped = sum[15:0];
    shift_byte = nvm.cal_word[15:8];
    shift_amt = shift_byte[SHIFT_MSB:SHIFT_LSB];
    if (sum[18]) begin
      clamped = 16'h0000;
    end else if (sum[17:16] != 2'h0) begin
      clamped = 16'hffff;
    end
    volt_res = clamped;
    if (chan_r == CH_EXTERNAL_MONITOR_THREE) begin
      volt_res = clamped >> shift_amt;
    end
  end

  // Temperature takes no gain. The stored word still carries the host's
  // key, which is undone here, and the sum saturates rather than wraps.
  always_comb begin
    logic [15:0] toff;
    logic [16:0] tsum;
    toff = offset_r ^ TEMP_OFFSET_KEY;
    tsum = {raw_r[15], raw_r} + {toff[15], toff};
    temp_res = tsum[15:0];
    if (tsum[16] != tsum[15]) begin
      temp_res = tsum[16] ? 16'h8000 : 16'h7fff;
    end
  end

  // Codes above the temperature channel pass the raw word through, which
  // lets a host see a conversion with no calibration applied.
  always_comb begin
    unique case (chan_r)
      CH_SUPPLY, CH_EXTERNAL_MONITOR_ONE, CH_EXTERNAL_MONITOR_TWO: result_nxt = volt_res;
      CH_EXTERNAL_MONITOR_THREE: result_nxt = volt_res;
      CH_TEMP: result_nxt = temp_res;
      default: result_nxt = raw_r;
    endcase
  end

  // Measurement sequencer; a start while busy is ignored. Each word is read
  // from the store one step after its index is set, so a calibration
  // write during a run may or may not be seen by that run.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= M_IDLE;
      chan_r <= CH_SUPPLY;
      raw_r <= 16'h0000;
      gain_r <= 16'h0000;
      offset_r <= 16'h0000;
    end else begin
      unique case (state_r)
        M_IDLE: begin
          if (meas_start_i) begin
            chan_r <= meas_chan_i;
            raw_r <= meas_raw_i;
            state_r <= M_GAIN;
          end
        end
        M_GAIN: state_r <= M_OFFSET;
        M_OFFSET: begin
          gain_r <= nvm.cal_word;
          state_r <= M_SHIFT;
        end
        M_SHIFT: begin
          offset_r <= nvm.cal_word;
          state_r <= M_DONE;
        end
        M_DONE: state_r <= M_IDLE;
      endcase
    end
  end

  // Done and the result move together, so a reader may take the result
  // on the pulse itself.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meas_result_o <= 16'h0000;
      meas_done_o <= 1'b0;
    end else begin
      meas_done_o <= (state_r == M_DONE);
      if (state_r == M_DONE) begin
        meas_result_o <= result_nxt;
      end
    end
  end

  // Busy covers the whole run, so a start is refused until done rises.
  assign meas_busy_o = (state_r != M_IDLE);

endmodule : mcp_bank

// *** sim/mcp_bank_chk.sv ***
// Port assertions for the calibration and password bank.
`timescale 1ns/1ps
module mcp_bank_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic reg_denied_o,
  // Access and measurement
  input wire logic pwe_wr_i,
  input wire logic first_level_access_o,
  input wire logic second_level_access_o,
  input wire logic meas_start_i,
  input wire logic meas_busy_o,
  input wire logic meas_done_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  logic outside;
  assign req = reg_wr_i || reg_rd_i;
  assign outside = reg_addr_i < 8'h8f || reg_addr_i > 8'hb7;
  sequence s_taken;
    meas_start_i && !meas_busy_o;
  endsequence
  sequence s_busy_run;
    meas_busy_o [*4] ##1 (meas_done_o && !meas_busy_o);
  endsequence
  a_ack_two_after: assert property (req |-> ##2 reg_ack_o)
    else $error("no answer two cycles after a strobe");
  a_ack_has_cause: assert property (reg_ack_o |-> $past(req, 2))
    else $error("answer without a strobe");
  a_read_refused: assert property (reg_rd_i
    && !second_level_access_o |-> ##2 (reg_denied_o && reg_rdata_o == 8'h00))
    else $error("read without access not refused");
  a_write_refused: assert property (reg_wr_i
    && !second_level_access_o |-> ##2 reg_denied_o)
    else $error("write without access not refused");
  a_pw_reads_zero: assert property (reg_rd_i && reg_addr_i >= 8'hb0
    && reg_addr_i <= 8'hb7 |-> ##2 reg_rdata_o == 8'h00)
    else $error("password byte read back nonzero");
  a_unmapped_denied: assert property (req && outside
    |-> ##2 reg_denied_o)
    else $error("unmapped access not refused");
  a_meas_five: assert property (s_taken |=> s_busy_run)
    else $error("measurement not done five cycles after start");
  a_done_has_start: assert property (meas_done_o
    |-> $past(meas_start_i, 5))
    else $error("done without a start");
  a_level_holds: assert property ($past(pwe_wr_i)
    || $past(reg_wr_i) || $past(reg_wr_i, 2)
    || ($stable(first_level_access_o) && $stable(second_level_access_o)))
    else $error("access level changed without a write");
endmodule : mcp_bank_chk

bind mcp_bank mcp_bank_chk u_chk (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .reg_ack_o, .reg_denied_o, .pwe_wr_i,
  .first_level_access_o, .second_level_access_o, .meas_start_i,
  .meas_busy_o, .meas_done_o);

// *** sim/mcp_host.sv ***
// Host model that drives the byte register port and the password entry.
`timescale 1ns/1ps
module mcp_host (
  // Clock
  input wire logic clock_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_ack_i,
  input wire logic reg_denied_i,
  // Password entry
  output logic pwe_wr_o,
  output logic [31:0] pwe_val_o
);
  import mcp_pkg::*;
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    pwe_wr_o = 1'b0;
    pwe_val_o = 32'h00000000;
  end
  // Idle address and data are inverted so no stale value looks valid.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic dn, output logic ak);
    @(posedge clock_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(posedge clock_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    @(posedge clock_i);
    #1;
    q = reg_rdata_i;
    dn = reg_denied_i;
    ak = reg_ack_i;
  endtask : xfer
  task automatic temp_wr(input logic [15:0] off);
    logic [15:0] v;
    logic [7:0] q;
    logic dn;
    logic ak;
    v = off ^ TEMP_OFFSET_KEY;
    xfer(1'b1, TEMP_OFFSET_ADDR, v[15:8], q, dn, ak);
    xfer(1'b1, TEMP_OFFSET_ADDR + 8'h01, v[7:0], q, dn, ak);
  endtask : temp_wr
  task automatic entry(input logic [31:0] v);
    @(posedge clock_i);
    #1;
    pwe_wr_o = 1'b1;
    pwe_val_o = v;
    @(posedge clock_i);
    #1;
    pwe_wr_o = 1'b0;
    pwe_val_o = ~v;
  endtask : entry
endmodule : mcp_host

// *** sim/test_mcp_bank.sv ***
// Self-checking bench for the calibration and password bank.
`timescale 1ns/1ps
module test_mcp_bank;
  import mcp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic reg_ack_o;
  logic reg_denied_o;
  logic pwe_wr_i;
  logic [31:0] pwe_val;
  logic first_level_access_o;
  logic second_level_access_o;
  logic meas_start_i;
  chan_t meas_chan_i;
  logic [15:0] meas_raw_i;
  logic meas_busy_o;
  logic meas_done_o;
  logic [15:0] meas_result_o;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [7:0] RA [10] = '{8'h8f, 8'h90, 8'h92, 8'h93, 8'h98,
    8'h9a, 8'ha3, 8'hae, 8'haf, 8'hb4};
  localparam logic [7:0] RE [10] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80,
    8'h00, 8'h00, 8'hbb, 8'h40, 8'h00};
  localparam logic [7:0] WA [10] = '{8'h8f, 8'ha2, 8'ha3, 8'h94, 8'h95,
    8'ha6, 8'ha7, 8'h98, 8'h99, 8'h9a};
  localparam logic [7:0] WD [10] = '{8'h3f, 8'h00, 8'h10, 8'h40, 8'h00,
    8'hff, 8'hf0, 8'hff, 8'hff, 8'h5a};
  always #5 clock_i = ~clock_i;
  mcp_host host (.clock_i(clock_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o), .reg_ack_i(reg_ack_o),
    .reg_denied_i(reg_denied_o), .pwe_wr_o(pwe_wr_i), .pwe_val_o(pwe_val));
  mcp_bank dut (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_ack_o, .reg_denied_o, .pwe_wr_i,
    .password_entry_value_i(pwe_val), .first_level_access_o,
    .second_level_access_o, .meas_start_i, .meas_chan_i, .meas_raw_i,
    .meas_busy_o, .meas_done_o, .meas_result_o);
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic give_verdict();
    $display("comparisons %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic den);
    logic [7:0] q;
    logic dn;
    logic ak;
    host.xfer(w, a, d, q, dn, ak);
    cmp_bit(ak, 1'b1);
    cmp_bit(dn, den);
    if (!w) begin
      cmp_val({8'h00, q}, {8'h00, e});
    end
  endtask : acc
  // A second start while busy carries other data and must be ignored.
  task automatic meas(input chan_t ch, input logic [15:0] raw,
                      input logic [15:0] e);
    int n;
    @(posedge clock_i);
    #1;
    meas_start_i = 1'b1;
    meas_chan_i = ch;
    meas_raw_i = raw;
    @(posedge clock_i);
    #1;
    meas_raw_i = ~raw;
    cmp_bit(meas_busy_o, 1'b1);
    @(posedge clock_i);
    #1;
    meas_start_i = 1'b0;
    n = 0;
    while (meas_done_o !== 1'b1 && n < 8) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    cmp_bit(meas_done_o, 1'b1);
    cmp_val(meas_result_o, e);
    cmp_bit(meas_busy_o, 1'b0);
  endtask : meas
  task automatic t_reset();
    cmp_bit(first_level_access_o, 1'b1);
    cmp_bit(second_level_access_o, 1'b1);
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, RA[i], 8'h00, RE[i], 1'b0);
    end
  endtask : t_reset
  task automatic t_meas();
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, WA[i], WD[i], 8'h00, 1'b0);
    end
    host.temp_wr(16'h0080);
    acc(1'b0, 8'h8f, 8'h00, 8'h3f, 1'b0);
    acc(1'b0, 8'h9a, 8'h00, 8'h5a, 1'b0);
    acc(1'b0, 8'haf, 8'h00, 8'hc0, 1'b0);
    meas(CH_SUPPLY, 16'h1000, 16'h0840);
    meas(CH_EXTERNAL_MONITOR_ONE, 16'h8000, 16'h2000);
    meas(CH_EXTERNAL_MONITOR_TWO, 16'h0020, 16'h0000);
    meas(CH_EXTERNAL_MONITOR_THREE, 16'hffff, 16'h1fff);
    meas(CH_TEMP, 16'h0100, 16'h0180);
    meas(3'h5, 16'h1234, 16'h1234);
  endtask : t_meas
  task automatic t_password();
    acc(1'b1, 8'hb0, 8'h12, 8'h00, 1'b0);
    cmp_bit(first_level_access_o, 1'b0);
    acc(1'b1, 8'hb1, 8'h34, 8'h00, 1'b0);
    acc(1'b1, 8'hb2, 8'h56, 8'h00, 1'b0);
    acc(1'b1, 8'hb3, 8'h78, 8'h00, 1'b0);
    host.entry(32'h12345678);
    cmp_bit(first_level_access_o, 1'b1);
    cmp_bit(second_level_access_o, 1'b0);
    acc(1'b0, 8'h8f, 8'h00, 8'h00, 1'b1);
    acc(1'b1, 8'h8f, 8'h55, 8'h00, 1'b1);
    acc(1'b1, 8'hb4, 8'h00, 8'h00, 1'b1);
    host.entry(32'hffffffff);
    cmp_bit(first_level_access_o, 1'b0);
    cmp_bit(second_level_access_o, 1'b1);
    acc(1'b0, 8'h8f, 8'h00, 8'h3f, 1'b0);
    acc(1'b1, 8'hb7, 8'h00, 8'h00, 1'b0);
    cmp_bit(second_level_access_o, 1'b0);
    host.entry(32'hffffff00);
    cmp_bit(second_level_access_o, 1'b1);
    acc(1'b0, 8'hb4, 8'h00, 8'h00, 1'b0);
    acc(1'b0, 8'hc0, 8'h00, 8'h00, 1'b1);
  endtask : t_password
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    rst_i = 1'b1;
    meas_start_i = 1'b0;
    meas_chan_i = CH_SUPPLY;
    meas_raw_i = 16'h0000;
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_meas();
    t_password();
    give_verdict();
  end
endmodule : test_mcp_bank
